// ===== rtl/wdt_pkg.sv
// Shared constants for the watchdog interval timer and its controller
package wdt_pkg;
  // Device register map
  localparam logic [15:0] CSEL_ADDR       = 16'hFF42;
  localparam logic [15:0] MODE_ADDR       = 16'hFFF9;
  localparam logic [7:0]  CSEL_RESET      = 8'h00;
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam int          RUN_BIT         = 7;
  localparam int          WD_MODE_BIT     = 4;
  localparam int          ACTION_BIT      = 3;
  localparam int          CSEL_MSB        = 2;
  // Counter geometry
  localparam int          PRESC_W         = 10;
  localparam int          CNT_W           = 7;
  localparam logic [6:0]  CNT_LAST        = 7'h7F;
  localparam logic [3:0]  PRESC_BASE_MASK = 4'hF;
  // Controller register map
  localparam logic [15:0] STATUS_ADDR     = 16'hFF00;
  localparam logic [15:0] MASK_ADDR       = 16'hFF01;
  localparam logic [15:0] CTRL_ADDR       = 16'hFF02;
  localparam logic [15:0] PEND_ADDR       = 16'hFF03;
  localparam logic [15:0] BITOP_ADDR      = 16'hFF04;
  localparam int          EV_INTERVAL     = 0;
  localparam int          EV_NMI          = 1;
  localparam int          EV_RESET        = 2;
  localparam int          CTRL_STOP       = 0;
  localparam int          CTRL_SUBCLK     = 1;
  localparam int          CTRL_IRQ_MASK   = 2;
  localparam int          BITOP_VAL       = 3;
  localparam int          BITOP_TARGET    = 4;
  localparam int          EXT_IRQS        = 4;
  // Operation modes
  typedef enum logic [1:0] {
    MODE_STOP, MODE_INTERVAL, MODE_WD_NMI, MODE_WD_RESET
  } wd_mode_t;
endpackage

// ===== rtl/wdt_if.sv
// Link between the watchdog timer and its CPU-side controller
`timescale 1ns/1ps
interface wdt_if;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_bit_wr;
  logic [2:0]  reg_bit_sel;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        stop_mode;
  logic        on_subclk;
  logic        wd_irq_pending_flag;
  logic        wd_interval_irq;
  logic        wd_nmi_req;
  logic        wd_reset_req;

  modport dev (
    input  reg_addr, reg_wdata, reg_wr, reg_bit_wr, reg_bit_sel, reg_rd,
    input  stop_mode, on_subclk, wd_irq_pending_flag,
    output reg_rdata, wd_interval_irq, wd_nmi_req, wd_reset_req
  );
  modport ctl (
    output reg_addr, reg_wdata, reg_wr, reg_bit_wr, reg_bit_sel, reg_rd,
    output stop_mode, on_subclk, wd_irq_pending_flag,
    input  reg_rdata, wd_interval_irq, wd_nmi_req, wd_reset_req
  );
endinterface

// ===== rtl/watchdog_interval_timer.sv
// Watchdog / interval timer counting a prescaled main clock
//
// What this block does
// - Select codes pick divide 16/64/256/1024
// - Writing run bit clears counter, starts counting
// - Run bit cannot be cleared by software
// - Mode field picks stop, interval, NMI, reset
// - Mode bits stay set until reset
// - Free prescaler may shorten first period slightly
// - Software checks pending flag before watchdog mode
// - Watchdog select with pending flag raises NMI
// - Missed refresh gives reset or NMI
// - Counts in halt, freezes in stop
// - Counter stops while CPU uses subsystem clock
// - Interval overflow raises maskable interval request
// - Interval request has top maskable priority
// - Clock select: byte writes only, reset 00H
// - Mode register: bit and byte writes, reset 00H
`timescale 1ns/1ps
module watchdog_interval_timer
  import wdt_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  wdt_if.dev        link
);

  typedef struct packed {
    logic [CSEL_MSB:0]  csel;
    logic               run;
    logic [1:0]         mode;
    logic [PRESC_W-1:0] presc;
    logic [CNT_W-1:0]   cnt;
    logic [7:0]         rdata;
    logic               ivl;
    logic               nmi;
    logic               rst;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;

  // Count clock tick for the selected divider
  function automatic logic tick_of(input logic [CSEL_MSB:0] sel,
                                   input logic [PRESC_W-1:0] presc);
    logic [PRESC_W-1:0] mask;
    mask = {{(PRESC_W-4){1'b0}}, PRESC_BASE_MASK};
    mask = (mask << {sel[2:1], 1'b0}) | mask;
    mask = mask | (mask >> 1) | (mask >> 2) | (mask >> 3);
    tick_of = ((presc & mask) == mask);
  endfunction

  // Register read image
  function automatic logic [7:0] read_of(input logic [15:0] addr,
                                         input core_state_t s);
    read_of = 8'h00;
    if (addr == CSEL_ADDR) begin
      read_of = {5'h00, s.csel};
    end else if (addr == MODE_ADDR) begin
      read_of = {s.run, 2'b00, s.mode, 3'b000};
    end
  endfunction

  logic       count_en;
  logic       tick;
  logic [7:0] set_bits;

  always_comb begin
    state_next = state_reg;
    state_next.ivl = 1'b0;
    state_next.nmi = 1'b0;
    state_next.rst = 1'b0;
    state_next.rdata = 8'h00;
    set_bits = 8'h00;

    // Frozen in stop and on subsystem clock, running otherwise
    count_en = !link.stop_mode && !link.on_subclk;
    // Prescaler is never cleared by a refresh
    if (count_en) begin
      state_next.presc = state_reg.presc + 1'b1;
    end
    tick = count_en && tick_of(state_reg.csel, state_reg.presc);

    if (state_reg.run && tick) begin
      state_next.cnt = state_reg.cnt + 1'b1;
      if (state_reg.cnt == CNT_LAST) begin
        case (wd_mode_t'(state_reg.mode))
          MODE_INTERVAL: begin
            state_next.ivl = 1'b1;
          end
          MODE_WD_NMI: begin
            state_next.nmi = 1'b1;
          end
          MODE_WD_RESET: begin
            state_next.rst = 1'b1;
          end
          default: begin
            state_next.ivl = 1'b0;
          end
        endcase
      end
    end

    // Clock select takes whole bytes only
    if (link.reg_wr && link.reg_addr == CSEL_ADDR) begin
      state_next.csel = link.reg_wdata[CSEL_MSB:0];
    end

    // Mode register: ones written in byte or bit form
    if (link.reg_addr == MODE_ADDR) begin
      if (link.reg_wr) begin
        set_bits = link.reg_wdata;
      end else if (link.reg_bit_wr && link.reg_wdata[0]) begin
        set_bits = 8'h01 << link.reg_bit_sel;
      end
    end

    if (set_bits[RUN_BIT]) begin
      state_next.run = 1'b1;
      state_next.cnt = '0;
    end
    state_next.mode = state_reg.mode | set_bits[WD_MODE_BIT:ACTION_BIT];

    if (set_bits[WD_MODE_BIT] && !state_reg.mode[1] && link.wd_irq_pending_flag) begin
      state_next.nmi = 1'b1;
    end

    if (link.reg_rd) begin
      state_next.rdata = read_of(link.reg_addr, state_reg);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.reg_rdata       = state_reg.rdata;
  assign link.wd_interval_irq = state_reg.ivl;
  assign link.wd_nmi_req      = state_reg.nmi;
  assign link.wd_reset_req    = state_reg.rst;

endmodule

// ===== rtl/wdt_cpu_controller.sv
// CPU-side controller: register access, interrupt flags and arbitration
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module wdt_cpu_controller
  import wdt_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                nrst_i,
  input  wire logic [15:0]         addr_i,
  input  wire logic [7:0]          wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  input  wire logic [EXT_IRQS-1:0] ext_irq_i,
  output logic      [7:0]          rdata_o,
  output logic                     irq_o,
  output logic                     nmi_o,
  output logic                     sys_reset_o,
  output logic                     cpu_irq_o,
  output logic      [2:0]          cpu_irq_src_o,
  wdt_if.ctl                       link
);

  typedef struct packed {
    logic [2:0] status;
    logic [2:0] mask;
    logic [2:0] ctrl;
    logic       pend;
    logic [7:0] own_rd;
    logic       rd_dev;
    logic       irq;
    logic       nmi;
    logic       rst;
    logic       cpu_irq;
    logic [2:0] src;
  } ctl_state_t;

  ctl_state_t state_reg;
  ctl_state_t state_next;

  logic       dev_addr;
  logic       bitop;
  logic [2:0] events;

  always_comb begin
    dev_addr = (addr_i == CSEL_ADDR) || (addr_i == MODE_ADDR);
    bitop    = wr_i && (addr_i == BITOP_ADDR);
    events   = {link.wd_reset_req, link.wd_nmi_req, link.wd_interval_irq};

    state_next = state_reg;
    state_next.own_rd = 8'h00;
    state_next.rd_dev = rd_i && dev_addr;
    state_next.nmi = link.wd_nmi_req;
    state_next.rst = link.wd_reset_req;

    if (wr_i && addr_i == MASK_ADDR) begin
      state_next.mask = wdata_i[2:0];
    end
    if (wr_i && addr_i == CTRL_ADDR) begin
      state_next.ctrl = wdata_i[2:0];
    end
    // Write one to clear; a same-cycle event wins
    if (wr_i && addr_i == STATUS_ADDR) begin
      state_next.status = state_reg.status & ~wdata_i[2:0];
    end
    state_next.status = state_next.status | events;
    if (wr_i && addr_i == PEND_ADDR && wdata_i[0]) begin
      state_next.pend = 1'b0;
    end
    if (link.wd_interval_irq || link.wd_nmi_req) begin
      state_next.pend = 1'b1;
    end
    state_next.irq = |(state_next.status & state_next.mask);

    if (rd_i) begin
      case (addr_i)
        STATUS_ADDR: state_next.own_rd = {5'h00, state_reg.status};
        MASK_ADDR:   state_next.own_rd = {5'h00, state_reg.mask};
        CTRL_ADDR:   state_next.own_rd = {5'h00, state_reg.ctrl};
        PEND_ADDR:   state_next.own_rd = {7'h00, state_reg.pend};
        default:     state_next.own_rd = 8'h00;
      endcase
    end

    // Watchdog request beats every external maskable source
    state_next.cpu_irq = 1'b0;
    state_next.src = 3'h0;
    if (state_next.pend && !state_reg.ctrl[CTRL_IRQ_MASK]) begin
      state_next.cpu_irq = 1'b1;
    end else begin
      for (int i = EXT_IRQS - 1; i >= 0; i--) begin
        if (ext_irq_i[i]) begin
          state_next.cpu_irq = 1'b1;
          state_next.src = 3'(i + 1);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Device accesses pass straight through so read data lands next cycle
  assign link.reg_addr    = bitop ? (wdata_i[BITOP_TARGET] ? MODE_ADDR : CSEL_ADDR) : addr_i;
  assign link.reg_wdata   = bitop ? {7'h00, wdata_i[BITOP_VAL]} : wdata_i;
  assign link.reg_wr      = wr_i && dev_addr;
  assign link.reg_bit_wr  = bitop;
  assign link.reg_bit_sel = wdata_i[2:0];
  assign link.reg_rd      = rd_i && dev_addr;
  assign link.stop_mode   = state_reg.ctrl[CTRL_STOP];
  assign link.on_subclk   = state_reg.ctrl[CTRL_SUBCLK];
  assign link.wd_irq_pending_flag = state_reg.pend;

  assign rdata_o       = state_reg.rd_dev ? link.reg_rdata : state_reg.own_rd;
  assign irq_o         = state_reg.irq;
  assign nmi_o         = state_reg.nmi;
  assign sys_reset_o   = state_reg.rst;
  assign cpu_irq_o     = state_reg.cpu_irq;
  assign cpu_irq_src_o = state_reg.src;

endmodule

// ===== tb/wdt_assertions.sv
// Concurrent checks on the timer link
`timescale 1ns/1ps
module wdt_assertions
  import wdt_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_bit_wr,
  input wire logic [2:0]  reg_bit_sel,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        stop_mode,
  input wire logic        on_subclk,
  input wire logic        wd_irq_pending_flag,
  input wire logic        wd_interval_irq,
  input wire logic        wd_nmi_req,
  input wire logic        wd_reset_req
);
  logic [2:0]  mode_reg;
  logic [11:0] gap_reg;
  logic        mwr;
  logic        mbit;
  logic        run_set;
  logic        ovf;
  logic        frz;
  assign mwr     = reg_wr && reg_addr == MODE_ADDR;
  assign mbit    = reg_bit_wr && reg_addr == MODE_ADDR && reg_wdata[0];
  assign run_set = (mwr && reg_wdata[7]) || (mbit && reg_bit_sel == 3'h7);
  assign ovf     = wd_interval_irq || wd_reset_req;
  assign frz     = stop_mode || on_subclk;
  // Sticky run and mode shadow, enabled cycles since last clear
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      mode_reg <= 3'h0;
      gap_reg  <= 12'h000;
    end else begin
      mode_reg <= mode_reg | {run_set, (mwr && reg_wdata[4]) || (mbit && reg_bit_sel == 3'h4),
                              (mwr && reg_wdata[3]) || (mbit && reg_bit_sel == 3'h3)};
      if (run_set || ovf)
        gap_reg <= 12'h000;
      else if (!frz && gap_reg != 12'hFFF)
        gap_reg <= gap_reg + 12'h001;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence wd_select;
    mwr && reg_wdata[WD_MODE_BIT] && !mode_reg[1] && wd_irq_pending_flag;
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_csel_unused: assert property (reg_rd && reg_addr == CSEL_ADDR |=> reg_rdata[7:3] == 5'h00)
    else $error("clock select unused bits not zero");
  a_mode_readback: assert property (reg_rd && reg_addr == MODE_ADDR |=>
    {reg_rdata[7], reg_rdata[4:3]} == $past(mode_reg) && reg_rdata[6:5] == 2'h0 && reg_rdata[2:0] == 3'h0)
    else $error("mode register readback wrong");
  a_event_onehot: assert property ($onehot0({wd_interval_irq, wd_nmi_req, wd_reset_req}))
    else $error("several events at once");
  a_stopped_quiet: assert property (mode_reg[1:0] == 2'h0 || !mode_reg[2] |-> !ovf)
    else $error("overflow event while stopped");
  a_interval_mode: assert property (wd_interval_irq |-> $past(mode_reg[1:0]) == 2'h1)
    else $error("interval event outside interval mode");
  a_reset_mode: assert property (wd_reset_req |-> $past(mode_reg[1:0]) == 2'h3)
    else $error("reset event outside reset mode");
  a_period_min: assert property (ovf |-> gap_reg >= 12'd2000)
    else $error("overflow too early");
  a_freeze_hold: assert property (frz && $past(frz) |-> !ovf)
    else $error("overflow while frozen");
  a_select_nmi: assert property (wd_select |=> wd_nmi_req)
    else $error("no nmi on watchdog select with pending flag");
endmodule

// ===== tb/tb.sv
// Self-checking bench for the timer and its controller
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb;
  import wdt_pkg::*;
  logic                sys_clk;
  logic                nrst;
  logic                wr;
  logic                rd;
  logic                rd_q;
  logic [15:0]         addr;
  logic [7:0]          wdata;
  logic [7:0]          rdata;
  logic [7:0]          e_v;
  logic [EXT_IRQS-1:0] ext_irq;
  logic                irq;
  logic                cpu_irq;
  logic [2:0]          cpu_src;
  logic                nmi;
  logic                sys_rst;
  logic [7:0]          exp_q[$];
  int                  fails;
  int                  n_checks;
  int                  n;
  int                  n_nmi;
  int                  n_rst;
  int                  seed = 98199;
  wdt_if link ();
  watchdog_interval_timer watchdog_interval_timer_i (.sys_clk_i(sys_clk), .nrst_i(nrst), .link(link));
  wdt_cpu_controller wdt_cpu_controller_i (.sys_clk_i(sys_clk), .nrst_i(nrst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .ext_irq_i(ext_irq), .rdata_o(rdata), .irq_o(irq),
    .nmi_o(nmi), .sys_reset_o(sys_rst), .cpu_irq_o(cpu_irq), .cpu_irq_src_o(cpu_src),
    .link(link));
  wdt_assertions wdt_assertions_i (.sys_clk_i(sys_clk), .nrst_i(nrst), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr), .reg_bit_wr(link.reg_bit_wr),
    .reg_bit_sel(link.reg_bit_sel), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata),
    .stop_mode(link.stop_mode), .on_subclk(link.on_subclk),
    .wd_irq_pending_flag(link.wd_irq_pending_flag), .wd_interval_irq(link.wd_interval_irq),
    .wd_nmi_req(link.wd_nmi_req), .wd_reset_req(link.wd_reset_req));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // One access; a read notes its expected data
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    if (w) wr <= 1'b1;
    else begin
      rd <= 1'b1;
      exp_q.push_back(d);
    end
    @(posedge sys_clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic finish_test();
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    ext_irq <= EXT_IRQS'($random(seed));
    if (nmi === 1'b1) n_nmi++;
    if (sys_rst === 1'b1) n_rst++;
    if (rd_q) begin
      e_v = exp_q.pop_front();
      `CHK(rdata, e_v)
    end
    rd_q <= rd;
  end
  initial begin
    #(30000 * 50);
    fails++;
    finish_test();
  end
  initial begin
    {nrst, wr, rd, rd_q, addr, wdata, ext_irq} = '0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    acc(0, CSEL_ADDR, 8'h00);
    acc(0, MODE_ADDR, 8'h00);
    acc(1, BITOP_ADDR, 8'h09);
    acc(1, BITOP_ADDR, 8'h1B);
    acc(0, CSEL_ADDR, 8'h00);
    acc(0, MODE_ADDR, 8'h08);
    acc(1, CSEL_ADDR, 8'hFF);
    acc(0, CSEL_ADDR, 8'h07);
    acc(1, CSEL_ADDR, 8'h00);
    acc(1, MASK_ADDR, 8'h07);
    acc(1, MODE_ADDR, 8'h88);
    n = 0;
    while (irq !== 1'b1 && n < 2200) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK(n >= 2030 && n <= 2054, 1'b1)
    repeat (2) @(posedge sys_clk);
    `CHK({cpu_irq, cpu_src}, 4'h8)
    acc(1, MASK_ADDR, 8'h00);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    acc(1, MODE_ADDR, 8'h00);
    acc(0, MODE_ADDR, 8'h88);
    acc(1, STATUS_ADDR, 8'h07);
    acc(0, STATUS_ADDR, 8'h00);
    acc(1, MODE_ADDR, 8'h10);
    acc(0, STATUS_ADDR, 8'h02);
    acc(0, MODE_ADDR, 8'h98);
    for (int v = 1; v <= 2; v++) begin
      acc(1, CTRL_ADDR, 8'(v));
      repeat (2200) @(posedge sys_clk);
      acc(0, STATUS_ADDR, 8'h02);
    end
    acc(1, CTRL_ADDR, 8'h00);
    repeat (3) begin
      repeat (1500) @(posedge sys_clk);
      acc(1, MODE_ADDR, 8'h80);
    end
    acc(0, STATUS_ADDR, 8'h02);
    repeat (2200) @(posedge sys_clk);
    acc(0, STATUS_ADDR, 8'h06);
    // Second reset mid-run, then watchdog mode 1 overflow
    nrst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    acc(0, MODE_ADDR, 8'h00);
    acc(0, PEND_ADDR, 8'h00);
    acc(1, MODE_ADDR, 8'h90);
    repeat (2200) @(posedge sys_clk);
    acc(0, STATUS_ADDR, 8'h02);
    acc(0, PEND_ADDR, 8'h01);
    repeat (3) @(posedge sys_clk);
    `CHK(n_nmi, 2)
    `CHK(n_rst, 1)
    finish_test();
  end
endmodule
